// *** verilog/crxf_pkg.sv ***
// Package: register map, field layout and encodings of the Rx queue block
// Function
// - Data size code selects bytes and words
// - Mode bit zero selects blocking, reset default
// - Blocking: full when put equals get, stop storing
// - Full sets status bit and full interrupt flag
// - Message on full blocking queue lost, flags set
// - Mode bit one selects overwrite mode
// - Error code zero after successful frame
// - Stuff error records code one
// - Form error records code two
// - Missing acknowledge records code three
// - Recessive sent, dominant seen records code four
// - Dominant sent, recessive seen records code five
// - Bus-off recovery eleven recessive bits records five
// - Checksum mismatch records code six
// - Status read resets error code to seven
// - Delay compensation writable only with both enables
// - Line select bits route sources to line one
package crxf_pkg;
  // ----------------------------------------------------------------
  // Register offsets
  // ----------------------------------------------------------------
  localparam logic [7:0] OFS_CORE_CONTROL = 8'h18;
  localparam logic [7:0] OFS_PROTO_STATUS = 8'h44;
  localparam logic [7:0] OFS_TDC          = 8'h48;
  localparam logic [7:0] OFS_IRQ_FLAGS    = 8'h50;
  localparam logic [7:0] OFS_IRQ_MASK     = 8'h54;
  localparam logic [7:0] OFS_LINE_SELECT  = 8'h58;
  localparam logic [7:0] OFS_Q_CONFIG     = 8'ha0;
  localparam logic [7:0] OFS_Q_STATUS     = 8'ha4;
  localparam logic [7:0] OFS_Q_ACK        = 8'ha8;
  localparam logic [7:0] OFS_ELEM_SIZE    = 8'hbc;
  // ----------------------------------------------------------------
  // Field positions and reset values
  // ----------------------------------------------------------------
  localparam int CC_INIT_BIT   = 0;
  localparam int CC_CCE_BIT    = 1;
  localparam int QC_MODE_BIT   = 31;
  localparam int QS_FULL_BIT   = 24;
  localparam int QS_LOST_BIT   = 25;
  localparam int QS_PUT_POS    = 16;
  localparam int QS_GET_POS    = 8;
  localparam int IR_NEW_BIT    = 0;
  localparam int IR_FULL_BIT   = 2;
  localparam int IR_LOST_BIT   = 3;
  localparam int LS_LOW_BIT    = 22;
  localparam int IRQ_W         = 4;
  localparam int QIDX_W        = 6;
  localparam int SRC_W         = 5;
  localparam logic [31:0] CC_RESET  = 32'h0000_0001;
  localparam logic [31:0] TDC_RESET = 32'h0000_0000;
  localparam logic [6:0]  TDC_MASK  = 7'h7f;
  localparam logic [QIDX_W-1:0] QSIZE_RESET = 6'h08;
  // ----------------------------------------------------------------
  // Last error code values
  // ----------------------------------------------------------------
  typedef enum logic [2:0] {
    LEC_NONE = 3'h0, LEC_STUFF = 3'h1, LEC_FORM = 3'h2, LEC_ACK = 3'h3,
    LEC_BIT1 = 3'h4, LEC_BIT0 = 3'h5, LEC_CRC = 3'h6, LEC_NC = 3'h7
  } crxf_lec_t;
  // Protocol events from the bit engine, one-cycle pulses
  typedef struct packed {
    logic ok;
    logic stuff;
    logic form;
    logic ack;
    logic bit1;
    logic bit0;
    logic recov11;
    logic crc;
  } crxf_err_t;
  // Received message offered for storage
  typedef struct packed {
    logic        valid;
    logic [31:0] word;
  } crxf_msg_t;
  // Write port into message RAM
  typedef struct packed {
    logic        we;
    logic [15:0] addr;
    logic [31:0] data;
  } crxf_ram_t;
  // Queue fill state machine
  typedef enum logic [2:0] {
    ST_IDLE = 3'b001, ST_STORE = 3'b010, ST_DROP = 3'b100
  } crxf_state_t;
endpackage : crxf_pkg

// *** verilog/crxf_top.sv ***
// Rx queue bookkeeping, error code, delay compensation and line routing
//
// The AXI4-Lite register port was decided locally.
`timescale 1ns/1ns
module crxf_top
  import crxf_pkg::*;
(
  input  wire logic              clk,
  input  wire logic              srst,
  input  wire logic [7:0]        s_axi_awaddr,
  input  wire logic              s_axi_awvalid,
  output logic                   s_axi_awready,
  input  wire logic [31:0]       s_axi_wdata,
  input  wire logic [3:0]        s_axi_wstrb,
  input  wire logic              s_axi_wvalid,
  output logic                   s_axi_wready,
  output logic [1:0]             s_axi_bresp,
  output logic                   s_axi_bvalid,
  input  wire logic              s_axi_bready,
  input  wire logic [7:0]        s_axi_araddr,
  input  wire logic              s_axi_arvalid,
  output logic                   s_axi_arready,
  output logic [31:0]            s_axi_rdata,
  output logic [1:0]             s_axi_rresp,
  output logic                   s_axi_rvalid,
  input  wire logic              s_axi_rready,
  input  wire crxf_msg_t         rx_msg,
  input  wire crxf_err_t         err_ev,
  input  wire logic [SRC_W-1:0]  src_ev,
  output crxf_ram_t              ram_wr,
  output logic [6:0]             tdc_value,
  output logic                   irq_line0,
  output logic                   irq_line1
);
  // ----------------------------------------------------------------
  // Registers
  // ----------------------------------------------------------------
  logic [31:0]        cc_q;
  logic [31:0]        tdc_q;
  logic [31:0]        qcfg_q;
  logic [2:0]         esz_q;
  logic [31:0]        lsel_q;
  logic [IRQ_W-1:0]   irf_q;
  logic [IRQ_W:0]     irm_q;
  logic [SRC_W-1:0]   srcf_q;
  logic [QIDX_W-1:0]  put_q;
  logic [QIDX_W-1:0]  get_q;
  logic [QIDX_W:0]    fill_q;
  logic               lost_q;
  crxf_lec_t          lec_q;
  crxf_state_t        st_q;
  logic [31:0]        msg_q;
  logic               aw_q;
  logic               w_q;
  logic [7:0]         awa_q;
  logic [31:0]        wd_q;
  logic [QIDX_W-1:0]  qsize;
  logic               full;
  logic               wr_go;
  logic               rd_go;
  logic               ack_wr;
  logic [QIDX_W-1:0]  ack_idx;
  logic [4:0]         esize;
  logic [6:0]         dbytes;
  assign qsize  = qcfg_q[QS_PUT_POS +: QIDX_W] == '0 ? QSIZE_RESET
                                                     : qcfg_q[QS_PUT_POS +: QIDX_W];
  assign full   = fill_q == {1'b0, qsize};
  // ----------------------------------------------------------------
  // Element size decode
  // ----------------------------------------------------------------
  always_comb begin
    case (esz_q)
      3'b000:  begin esize = 5'd4;  dbytes = 7'd8;  end
      3'b001:  begin esize = 5'd5;  dbytes = 7'd12; end
      3'b010:  begin esize = 5'd6;  dbytes = 7'd16; end
      3'b011:  begin esize = 5'd7;  dbytes = 7'd20; end
      3'b100:  begin esize = 5'd8;  dbytes = 7'd24; end
      3'b101:  begin esize = 5'd10; dbytes = 7'd32; end
      3'b110:  begin esize = 5'd14; dbytes = 7'd48; end
      default: begin esize = 5'd18; dbytes = 7'd64; end
    endcase
  end
  // ----------------------------------------------------------------
  // AXI4-Lite slave
  // ----------------------------------------------------------------
  assign wr_go  = aw_q && w_q && !s_axi_bvalid;
  assign rd_go  = s_axi_arvalid && s_axi_arready;
  assign ack_wr = wr_go && awa_q == OFS_Q_ACK;
  assign ack_idx = wd_q[QIDX_W-1:0];
  always_ff @(posedge clk) begin
    if (srst) begin
      aw_q <= 1'b0;
      w_q <= 1'b0;
      awa_q <= 8'h00;
      wd_q <= 32'h0000_0000;
      s_axi_awready <= 1'b0;
      s_axi_wready <= 1'b0;
      s_axi_bvalid <= 1'b0;
      s_axi_bresp <= 2'b00;
    end else begin
      s_axi_awready <= !aw_q && !s_axi_awready && s_axi_awvalid;
      s_axi_wready <= !w_q && !s_axi_wready && s_axi_wvalid;
      if (s_axi_awvalid && s_axi_awready) begin
        aw_q <= 1'b1;
        awa_q <= s_axi_awaddr;
      end
      if (s_axi_wvalid && s_axi_wready) begin
        w_q <= 1'b1;
        wd_q <= s_axi_wdata;
      end
      if (wr_go) begin
        aw_q <= 1'b0;
        w_q <= 1'b0;
        s_axi_bvalid <= 1'b1;
        s_axi_bresp <= 2'b00;
      end else if (s_axi_bready) begin
        s_axi_bvalid <= 1'b0;
      end
    end
  end
  always_ff @(posedge clk) begin
    if (srst) begin
      s_axi_arready <= 1'b0;
      s_axi_rvalid <= 1'b0;
      s_axi_rdata <= 32'h0000_0000;
      s_axi_rresp <= 2'b00;
    end else begin
      s_axi_arready <= !s_axi_arready && !s_axi_rvalid && s_axi_arvalid;
      if (rd_go) begin
        s_axi_rvalid <= 1'b1;
        s_axi_rresp <= 2'b00;
        case (s_axi_araddr)
          OFS_CORE_CONTROL: s_axi_rdata <= cc_q;
          OFS_PROTO_STATUS: s_axi_rdata <= {29'h0, lec_q};
          OFS_TDC:          s_axi_rdata <= tdc_q;
          OFS_IRQ_FLAGS:    s_axi_rdata <= {27'h0, srcf_q == '0 ? 1'b0 : 1'b1, irf_q};
          OFS_IRQ_MASK:     s_axi_rdata <= {27'h0, irm_q};
          OFS_LINE_SELECT:  s_axi_rdata <= lsel_q;
          OFS_Q_CONFIG:     s_axi_rdata <= qcfg_q;
          OFS_Q_STATUS:     s_axi_rdata <= {6'h0, lost_q, full, 2'h0, put_q,
                                            2'h0, get_q, 1'b0, fill_q};
          OFS_ELEM_SIZE:    s_axi_rdata <= {17'h0, dbytes, 3'h0, esize};
          default: begin
            s_axi_rdata <= 32'h0000_0000;
            s_axi_rresp <= 2'b10;
          end
        endcase
      end else if (s_axi_rready) begin
        s_axi_rvalid <= 1'b0;
      end
    end
  end
  // ----------------------------------------------------------------
  // Configuration registers
  // ----------------------------------------------------------------
  always_ff @(posedge clk) begin
    if (srst) begin
      cc_q <= CC_RESET;
      tdc_q <= TDC_RESET;
      qcfg_q <= 32'h0000_0000;
      esz_q <= 3'b000;
      lsel_q <= 32'h0000_0000;
      irm_q <= '0;
    end else if (wr_go) begin
      case (awa_q)
        OFS_CORE_CONTROL: cc_q <= {30'h0, wd_q[CC_CCE_BIT],
                                   wd_q[CC_INIT_BIT]};
        OFS_TDC: begin
          // Locked out while running so the compensation cannot shift mid-frame
          if (cc_q[CC_CCE_BIT] && cc_q[CC_INIT_BIT]) begin
            tdc_q <= {25'h0, wd_q[6:0] & TDC_MASK};
          end
        end
        OFS_Q_CONFIG:    qcfg_q <= wd_q;
        OFS_ELEM_SIZE:   esz_q <= wd_q[2:0];
        OFS_IRQ_MASK:    irm_q <= wd_q[IRQ_W:0];
        OFS_LINE_SELECT: lsel_q <= {5'h0, wd_q[26:22], 22'h0};
        default: ;
      endcase
    end
  end
  // ----------------------------------------------------------------
  // Queue fill state machine
  // ----------------------------------------------------------------
  always_ff @(posedge clk) begin
    if (srst) begin
      st_q <= ST_IDLE;
      msg_q <= 32'h0000_0000;
    end else begin
      case (st_q)
        ST_IDLE: begin
          if (rx_msg.valid) begin
            msg_q <= rx_msg.word;
            // Blocking mode discards when full; overwrite stores anyway
            st_q <= (full && !qcfg_q[QC_MODE_BIT]) ? ST_DROP : ST_STORE;
          end
        end
        ST_STORE: st_q <= ST_IDLE;
        ST_DROP:  st_q <= ST_IDLE;
        default:  st_q <= ST_IDLE;
      endcase
    end
  end
  // Element address: start plus put index times element words
  always_ff @(posedge clk) begin
    if (srst) begin
      ram_wr <= '0;
    end else begin
      ram_wr.we <= st_q == ST_STORE;
      ram_wr.addr <= qcfg_q[15:0] + 16'(put_q) * 16'(esize);
      ram_wr.data <= msg_q;
    end
  end
  logic q_store;
  logic q_over;
  logic q_pop;
  assign q_store = st_q == ST_STORE;
  assign q_over  = q_store && full;
  assign q_pop   = ack_wr && fill_q != '0 && !q_over;
  // Indices; software acknowledges by writing the last index read
  always_ff @(posedge clk) begin
    if (srst) begin
      put_q <= '0;
      get_q <= '0;
      fill_q <= '0;
    end else begin
      if (q_store) begin
        put_q <= put_q + 1'b1 == qsize ? '0 : put_q + 1'b1;
      end
      if (q_over || q_pop) begin
        get_q <= (q_pop ? ack_idx : get_q) + 1'b1 == qsize ? '0
               : (q_pop ? ack_idx : get_q) + 1'b1;
      end
      if (q_store && !q_over && !q_pop) begin
        fill_q <= fill_q + 1'b1;
      end else if (q_pop && !q_store) begin
        fill_q <= fill_q - 1'b1;
      end
    end
  end
  // ----------------------------------------------------------------
  // Status flags and interrupts
  // ----------------------------------------------------------------
  logic irf_rd;
  logic [IRQ_W-1:0] irf_set;
  assign irf_rd = rd_go && s_axi_araddr == OFS_IRQ_FLAGS;
  assign irf_set = {st_q == ST_DROP, full && ram_wr.we, 1'b0, ram_wr.we};
  always_ff @(posedge clk) begin
    if (srst) begin
      irf_q <= '0;
      srcf_q <= '0;
      lost_q <= 1'b0;
    end else begin
      // Set wins over clear-on-read
      irf_q <= (irf_rd ? '0 : irf_q) | irf_set;
      srcf_q <= (irf_rd ? '0 : srcf_q) | src_ev;
      if (st_q == ST_DROP) begin
        lost_q <= 1'b1;
      end else if (rd_go && s_axi_araddr == OFS_Q_STATUS) begin
        lost_q <= 1'b0;
      end
    end
  end
  // Line routing; queue events go to line 0
  // Mask bit 4 gates the five routed sources on both lines; queue events on line 0 follow mask bits 3 to 0
  always_ff @(posedge clk) begin
    if (srst) begin
      irq_line0 <= 1'b0;
      irq_line1 <= 1'b0;
      tdc_value <= 7'h00;
    end else begin
      irq_line0 <= |(irf_q & irm_q[IRQ_W-1:0])
                   | (irm_q[IRQ_W] & (|(srcf_q & ~lsel_q[LS_LOW_BIT +: SRC_W])));
      irq_line1 <= irm_q[IRQ_W] & (|(srcf_q & lsel_q[LS_LOW_BIT +: SRC_W]));
      tdc_value <= tdc_q[6:0];
    end
  end
  // ----------------------------------------------------------------
  // Last error code
  // ----------------------------------------------------------------
  always_ff @(posedge clk) begin
    if (srst) begin
      lec_q <= LEC_NC;
    end else if (err_ev.crc) begin
      lec_q <= LEC_CRC;
    end else if (err_ev.bit0 || err_ev.recov11) begin
      lec_q <= LEC_BIT0;
    end else if (err_ev.bit1) begin
      lec_q <= LEC_BIT1;
    end else if (err_ev.ack) begin
      lec_q <= LEC_ACK;
    end else if (err_ev.form) begin
      lec_q <= LEC_FORM;
    end else if (err_ev.stuff) begin
      lec_q <= LEC_STUFF;
    end else if (err_ev.ok) begin
      lec_q <= LEC_NONE;
    end else if (rd_go && s_axi_araddr == OFS_PROTO_STATUS) begin
      lec_q <= LEC_NC;
    end
  end
  // ----------------------------------------------------------------
  // Checks
  // ----------------------------------------------------------------
  drop_when_full_a: assert property (@(posedge clk) disable iff (srst)
    st_q == ST_IDLE && rx_msg.valid && full && !qcfg_q[QC_MODE_BIT] |=> st_q == ST_DROP)
    else $error("blocking full queue did not drop");
  lost_flag_set_a: assert property (@(posedge clk) disable iff (srst)
    st_q == ST_DROP |=> lost_q && irf_q[IR_LOST_BIT])
    else $error("lost flags not set");
  overwrite_store_a: assert property (@(posedge clk) disable iff (srst)
    st_q == ST_IDLE && rx_msg.valid && qcfg_q[QC_MODE_BIT] |=> st_q == ST_STORE)
    else $error("overwrite mode refused message");
  lec_read_a: assert property (@(posedge clk) disable iff (srst)
    rd_go && s_axi_araddr == OFS_PROTO_STATUS && err_ev == '0 |=> lec_q == LEC_NC)
    else $error("error code not reset by read");
  lec_crc_a: assert property (@(posedge clk) disable iff (srst)
    err_ev.crc |=> lec_q == LEC_CRC)
    else $error("crc code not recorded");
  lec_stuff_a: assert property (@(posedge clk) disable iff (srst)
    err_ev == 8'h40 |=> lec_q == LEC_STUFF)
    else $error("stuff code not recorded");
  lec_recov_a: assert property (@(posedge clk) disable iff (srst)
    err_ev.recov11 && !err_ev.crc |=> lec_q == LEC_BIT0)
    else $error("recovery code not recorded");
  tdc_lock_a: assert property (@(posedge clk) disable iff (srst)
    !(cc_q[CC_CCE_BIT] && cc_q[CC_INIT_BIT]) |=> $stable(tdc_q))
    else $error("delay compensation written while locked");
  line_route_a: assert property (@(posedge clk) disable iff (srst)
    srcf_q[4] && lsel_q[26] && irm_q[IRQ_W] |=> irq_line1)
    else $error("watchdog not routed to line 1");
  elem_size_a: assert property (@(posedge clk) disable iff (srst)
    esz_q == 3'b111 |-> esize == 5'd18 && dbytes == 7'd64)
    else $error("element size decode wrong");
  elem_size_min_a: assert property (@(posedge clk) disable iff (srst)
    esz_q == 3'b000 |-> esize == 5'd4 && dbytes == 7'd8)
    else $error("smallest element size decode wrong");
  mode_default_a: assert property (@(posedge clk) disable iff (srst)
    $fell(srst) |-> !qcfg_q[QC_MODE_BIT])
    else $error("queue not in blocking mode after reset");
  full_index_a: assert property (@(posedge clk) disable iff (srst)
    full |-> put_q == get_q)
    else $error("full queue with put and get apart");
  blocking_hold_a: assert property (@(posedge clk) disable iff (srst)
    full && !qcfg_q[QC_MODE_BIT] |=> $stable(put_q))
    else $error("full blocking queue moved put index");
  full_flag_set_a: assert property (@(posedge clk) disable iff (srst)
    ram_wr.we && full |=> irf_q[IR_FULL_BIT])
    else $error("full interrupt flag not set");
  drop_discard_a: assert property (@(posedge clk) disable iff (srst)
    st_q == ST_DROP |=> !ram_wr.we)
    else $error("dropped message was written");
  over_keep_fill_a: assert property (@(posedge clk) disable iff (srst)
    st_q == ST_STORE && full |=> $stable(fill_q))
    else $error("overwrite changed fill count");
  lec_ok_a: assert property (@(posedge clk) disable iff (srst)
    err_ev == 8'h80 |=> lec_q == LEC_NONE)
    else $error("no error code not recorded");
  lec_form_a: assert property (@(posedge clk) disable iff (srst)
    err_ev == 8'h20 |=> lec_q == LEC_FORM)
    else $error("form code not recorded");
  lec_ack_a: assert property (@(posedge clk) disable iff (srst)
    err_ev == 8'h10 |=> lec_q == LEC_ACK)
    else $error("acknowledge code not recorded");
  lec_bit1_a: assert property (@(posedge clk) disable iff (srst)
    err_ev == 8'h08 |=> lec_q == LEC_BIT1)
    else $error("recessive bit code not recorded");
  lec_bit0_a: assert property (@(posedge clk) disable iff (srst)
    err_ev.bit0 && !err_ev.crc |=> lec_q == LEC_BIT0)
    else $error("dominant bit code not recorded");
  line0_route_a: assert property (@(posedge clk) disable iff (srst)
    srcf_q[0] && irm_q[IRQ_W] && !lsel_q[LS_LOW_BIT] |=> irq_line0)
    else $error("log overflow not routed to line 0");
  line1_mask_a: assert property (@(posedge clk) disable iff (srst)
    !irm_q[IRQ_W] |=> !irq_line1)
    else $error("masked sources reached line 1");
endmodule : crxf_top

// *** sim/crxf_can_node.sv ***
// Far-side model: other bus nodes and the protocol event sources
`timescale 1ns/1ns
module crxf_can_node
  import crxf_pkg::*;
(
  input  wire logic        clk,
  output crxf_msg_t        rx_msg,
  output crxf_err_t        err_ev,
  output logic [SRC_W-1:0] src_ev
);
  // ----------------------------------------------------------------
  // Idle levels
  // ----------------------------------------------------------------
  initial begin
    rx_msg = '0;
    err_ev = '0;
    src_ev = '0;
  end
  // ----------------------------------------------------------------
  // Delivery, called right after a rising edge
  // ----------------------------------------------------------------
  // Word flips when valid drops, so a stale payload never looks like data
  task automatic send_msg(input logic [31:0] w);
    rx_msg <= '{valid: 1'b1, word: w};
    @(posedge clk);
    rx_msg <= '{valid: 1'b0, word: ~w};
    @(posedge clk);
  endtask : send_msg
  task automatic pulse_err(input crxf_err_t e);
    err_ev <= e;
    @(posedge clk);
    err_ev <= '0;
    @(posedge clk);
  endtask : pulse_err
  task automatic pulse_src(input logic [SRC_W-1:0] s);
    src_ev <= s;
    @(posedge clk);
    src_ev <= '0;
    @(posedge clk);
  endtask : pulse_src
endmodule : crxf_can_node

// *** sim/tb.sv ***
// Self-checking bench for the Rx queue, error code and line routing block
`timescale 1ns/1ns
module tb;
  import crxf_pkg::*;
  // ----------------------------------------------------------------
  // Signals and instances
  // ----------------------------------------------------------------
  logic             clk, srst;
  logic [7:0]       s_axi_awaddr, s_axi_araddr;
  logic [31:0]      s_axi_wdata, s_axi_rdata, rd;
  logic [3:0]       s_axi_wstrb;
  logic [1:0]       s_axi_bresp, s_axi_rresp, resp;
  logic             s_axi_awvalid, s_axi_awready, s_axi_wvalid, s_axi_wready;
  logic             s_axi_bvalid, s_axi_bready, s_axi_arvalid, s_axi_arready;
  logic             s_axi_rvalid, s_axi_rready, irq_line0, irq_line1;
  logic [6:0]       tdc_value;
  crxf_msg_t        rx_msg;
  crxf_err_t        err_ev;
  logic [SRC_W-1:0] src_ev;
  crxf_ram_t        ram_wr;
  int               failures, n_tests, guard;
  logic [15:0]      ram_a[$];
  logic [31:0]      ram_d[$];
  logic [6:0]       bytes_t[8] = '{7'd8, 7'd12, 7'd16, 7'd20, 7'd24, 7'd32, 7'd48, 7'd64};
  logic [4:0]       words_t[8] = '{5'd4, 5'd5, 5'd6, 5'd7, 5'd8, 5'd10, 5'd14, 5'd18};
  logic [2:0]       lec_t[8]   = '{3'h0, 3'h1, 3'h2, 3'h3, 3'h4, 3'h5, 3'h5, 3'h6};
  crxf_top dut (.clk, .srst, .s_axi_awaddr, .s_axi_awvalid, .s_axi_awready, .s_axi_wdata,
    .s_axi_wstrb, .s_axi_wvalid, .s_axi_wready, .s_axi_bresp, .s_axi_bvalid, .s_axi_bready,
    .s_axi_araddr, .s_axi_arvalid, .s_axi_arready, .s_axi_rdata, .s_axi_rresp,
    .s_axi_rvalid, .s_axi_rready, .rx_msg, .err_ev, .src_ev, .ram_wr, .tdc_value,
    .irq_line0, .irq_line1);
  crxf_can_node node (.clk, .rx_msg, .err_ev, .src_ev);
  initial begin
    clk = 1'b0;
    forever #20 clk = ~clk;
  end
  always @(posedge clk) begin
    if (ram_wr.we === 1'b1) begin
      ram_a.push_back(ram_wr.addr);
      ram_d.push_back(ram_wr.data);
    end
  end
  // ----------------------------------------------------------------
  // Tasks
  // ----------------------------------------------------------------
  task automatic complete_run;
    $display("comparisons %0d mismatches %0d", n_tests, failures);
    if (failures == 0 && n_tests > 0) $display("*** PASS ***");
    else $display("*** FAIL ***");
    $finish;
  endtask : complete_run
  task automatic check(input logic [31:0] got, input logic [31:0] exp, input string what);
    n_tests++;
    if (got !== exp) begin
      failures++;
      $display("wrong value at %0t: %s got %h want %h", $time, what, got, exp);
    end
  endtask : check
  // Every handshake wait goes through here so a stuck slave cannot hang the run
  task automatic tick;
    @(posedge clk);
    guard++;
    if (guard > 64) begin
      failures++;
      $display("wrong value at %0t: handshake timed out", $time);
      complete_run();
    end
  endtask : tick
  task automatic wr(input logic [7:0] a, input logic [31:0] d);
    s_axi_awaddr <= a;
    s_axi_wdata <= d;
    s_axi_awvalid <= 1'b1;
    s_axi_wvalid <= 1'b1;
    s_axi_bready <= 1'b1;
    guard = 0;
    do begin
      tick();
      if (s_axi_awready === 1'b1) s_axi_awvalid <= 1'b0;
      if (s_axi_wready === 1'b1) s_axi_wvalid <= 1'b0;
    end while (s_axi_bvalid !== 1'b1);
    resp = s_axi_bresp;
    s_axi_bready <= 1'b0;
    @(posedge clk);
  endtask : wr
  task automatic rdc(input logic [7:0] a, input logic [31:0] m, input logic [31:0] e,
                     input string what);
    s_axi_araddr <= a;
    s_axi_arvalid <= 1'b1;
    s_axi_rready <= 1'b1;
    guard = 0;
    do begin
      tick();
      if (s_axi_arready === 1'b1) s_axi_arvalid <= 1'b0;
    end while (s_axi_rvalid !== 1'b1);
    rd = s_axi_rdata;
    resp = s_axi_rresp;
    s_axi_rready <= 1'b0;
    @(posedge clk);
    check(rd & m, e, what);
  endtask : rdc
  task automatic chk_ram(input logic [15:0] a, input logic [31:0] d);
    check({31'h0, ram_a.size() > 0}, 32'h1, "ram write seen");
    if (ram_a.size() > 0) begin
      check({16'h0, ram_a.pop_front()}, {16'h0, a}, "ram address");
      check(ram_d.pop_front(), d, "ram data");
    end
  endtask : chk_ram
  task automatic wait_lines(input logic [1:0] e);
    guard = 0;
    while ({irq_line1, irq_line0} !== e && guard < 8) begin
      @(posedge clk);
      guard++;
    end
    check({30'h0, irq_line1, irq_line0}, {30'h0, e}, "interrupt lines");
  endtask : wait_lines
  task automatic do_reset;
    srst <= 1'b1;
    repeat (2) @(posedge clk);
    srst <= 1'b0;
    repeat (2) @(posedge clk);
    ram_a.delete();
    ram_d.delete();
  endtask : do_reset
  // ----------------------------------------------------------------
  // Main sequence
  // ----------------------------------------------------------------
  initial begin
    failures = 0;
    n_tests = 0;
    {s_axi_awaddr, s_axi_araddr, s_axi_wdata, s_axi_wstrb} = {16'h0, 32'h0, 4'hf};
    {s_axi_awvalid, s_axi_wvalid, s_axi_bready, s_axi_arvalid, s_axi_rready} = '0;
    do_reset();
    rdc(OFS_TDC, 32'hffff_ffff, TDC_RESET, "tdc reset");
    rdc(OFS_CORE_CONTROL, 32'h3, 32'h1, "control reset");
    rdc(OFS_PROTO_STATUS, 32'h7, 32'h7, "code reset");
    rdc(OFS_Q_CONFIG, 32'h8000_0000, 32'h0, "mode reset");
    rdc(8'hfc, 32'hffff_ffff, 32'h0, "unmapped data");
    check({30'h0, resp}, 32'h2, "unmapped read resp");
    wr(8'hfc, 32'hffff_ffff);
    check({30'h0, resp}, 32'h0, "unmapped write resp");
    for (int i = 0; i < 8; i++) begin
      wr(OFS_ELEM_SIZE, 32'(i));
      rdc(OFS_ELEM_SIZE, 32'h7f1f, {17'h0, bytes_t[i], 3'h0, words_t[i]}, "size");
    end
    wr(OFS_TDC, 32'h55);
    rdc(OFS_TDC, 32'h7f, 32'h0, "tdc locked");
    wr(OFS_CORE_CONTROL, 32'h3);
    wr(OFS_TDC, 32'h55);
    rdc(OFS_TDC, 32'h7f, 32'h55, "tdc open");
    check({25'h0, tdc_value}, 32'h55, "tdc port");
    wr(OFS_CORE_CONTROL, 32'h2);
    wr(OFS_TDC, 32'h2a);
    rdc(OFS_TDC, 32'h7f, 32'h55, "tdc init off");
    $display("test registers finished");
    do_reset();
    wr(OFS_CORE_CONTROL, 32'h0);
    wr(OFS_Q_CONFIG, 32'h0004_0100);
    wr(OFS_ELEM_SIZE, 32'h2);
    for (int i = 0; i < 4; i++) node.send_msg(32'ha000_0000 + i);
    rdc(OFS_Q_STATUS, 32'h033f_3f7f, 32'h0100_0004, "full");
    rdc(OFS_IRQ_FLAGS, 32'h5, 32'h5, "full flag");
    for (int i = 0; i < 4; i++) chk_ram(16'h0100 + 16'(6 * i), 32'ha000_0000 + i);
    node.send_msg(32'h5a00_0005);
    rdc(OFS_Q_STATUS, 32'h033f_3f7f, 32'h0300_0004, "lost");
    rdc(OFS_IRQ_FLAGS, 32'h9, 32'h8, "lost flag");
    check(32'(ram_a.size()), 32'h0, "no store when full");
    wr(OFS_Q_ACK, 32'h0);
    rdc(OFS_Q_STATUS, 32'h033f_3f7f, 32'h0000_0103, "after ack");
    node.send_msg(32'ha000_0006);
    rdc(OFS_Q_STATUS, 32'h033f_3f7f, 32'h0101_0104, "refill");
    chk_ram(16'h0100, 32'ha000_0006);
    $display("test blocking finished");
    do_reset();
    wr(OFS_CORE_CONTROL, 32'h0);
    wr(OFS_Q_CONFIG, 32'h8004_0100);
    rdc(OFS_Q_CONFIG, 32'h8000_0000, 32'h8000_0000, "mode set");
    for (int i = 0; i < 5; i++) node.send_msg(32'hc000_0000 + i);
    rdc(OFS_Q_STATUS, 32'h033f_3f7f, 32'h0101_0104, "overwrite");
    rdc(OFS_IRQ_FLAGS, 32'h8, 32'h0, "no loss");
    for (int i = 0; i < 5; i++) chk_ram(16'h0100 + 16'(4 * (i % 4)), 32'hc000_0000 + i);
    $display("test overwrite finished");
    for (int i = 0; i < 8; i++) begin
      node.pulse_err(crxf_err_t'(8'h80 >> i));
      rdc(OFS_PROTO_STATUS, 32'h7, {29'h0, lec_t[i]}, "code");
      rdc(OFS_PROTO_STATUS, 32'h7, 32'h7, "code cleared");
    end
    node.pulse_err(crxf_err_t'(8'h41));
    rdc(OFS_PROTO_STATUS, 32'h7, 32'h6, "code priority");
    $display("test error code finished");
    wr(OFS_IRQ_MASK, 32'h10);
    for (int i = 0; i < 5; i++) begin
      for (int s = 0; s < 2; s++) begin
        wr(OFS_LINE_SELECT, s ? 32'h1 << (LS_LOW_BIT + i) : 32'h0);
        node.pulse_src(5'(1 << i));
        wait_lines(s ? 2'b10 : 2'b01);
        rdc(OFS_IRQ_FLAGS, 32'h10, 32'h10, "source flag");
        wait_lines(2'b00);
      end
    end
    wr(OFS_IRQ_MASK, 32'h0);
    node.pulse_src(5'h1);
    repeat (4) @(posedge clk);
    wait_lines(2'b00);
    rdc(OFS_IRQ_FLAGS, 32'h10, 32'h10, "masked flag");
    $display("test lines finished");
    complete_run();
  end
endmodule : tb
